// File: verilog/pmca_top.sv
// macrocell logic array top: pins, configuration port, power-up clear, fuse, signature
// assumes pins synchronous to core_clk; the clock pin is sampled and edge-detected
// assumes the board meets setup before the first clock pin edge after power-up
// assumes software finishes the configuration before it sets the fuse
// assumes the term window holds sixteen addresses per cell, ten of them used
`timescale 1ns/1ps

// Notes on behaviour
// - power-up clears every macrocell register low
// - registered outputs read high after clear
// - preload forces any register high or low
// - 64-bit signature readable in every state
// - fuse blocks pattern readback and preload
// - cells: registered, comb io, comb out, input
// - three global modes selectable
// - any register use forces registered mode
// - registered cell: clock pin, oe pin, eight terms
// - comb cell: term enable, seven-term sum
// - input cell driver off, except outer cells in complex and centre cells in simple
// - complex: seven terms, oe term, outer output-only
// - simple: eight terms, centre cells fixed outputs
module pmca_top
   import pmca_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [ARRAY_INPUTS-1:0] inPins,
   input wire logic [ARRAY_INPUTS-1:0] inDriven,
   input wire logic [CELLS-1:0] ioIn,
   input wire logic [CELLS-1:0] ioDriven,
   input wire logic clkPin,
   input wire logic oePinN,
   input wire pmca_req_t req,
   output logic [31:0] rdata,
   output logic [CELLS-1:0] ioOut,
   output logic [CELLS-1:0] ioOe,
   output logic powerUpDone
);
   // configuration written by software
   pmca_mode_t modeCfg;
   pmca_mode_t mode;
   pmca_cell_t cellCfg [CELLS];
   logic [TERMS_PER_CELL*TERM_WIDTH-1:0] termMem [CELLS];
   logic [SIG_BITS-1:0] signature;
   logic fuse;

   // power-up sequencer and clock pin sampling
   logic [PRC_W-1:0] puCount;
   pmca_pu_t puState;
   pmca_pu_t next_puState;
   logic clkPinQ;
   logic clkEdge;
   logic puClear;
   logic preloadStb;
   logic [CELLS-1:0] preloadMask;
   logic [CELLS-1:0] preloadVals;

   // array datapath
   logic [CELLS-1:0] regQ;
   logic [CELLS-1:0] pinOut;
   logic [CELLS-1:0] pinOe;
   logic [CELLS-1:0] fbVal;
   logic [ARRAY_INPUTS-1:0] inVal;
   logic [ARRAY_INPUTS+CELLS-1:0] arrayIn;
   logic [TERM_WIDTH-1:0] lits;
   logic anyReg;
   logic [CELLS-1:0] cellIsReg;

   // register port decode
   logic [ADDR_W-1:0] termIdx;
   logic [4:0] termWord;
   logic [2:0] termCell;
   logic termHit;
   logic [15:0] cfgPacked;
   logic [31:0] next_rdata;

   // undriven pins float high via pull-ups; the board lets released lines wander,
   // so the logic must never look at a raw undriven level
   assign inVal = inPins | ~inDriven;

   // power-up sequencer: clear registers, then count out the reset interval
   // the interval is counted in core clocks, rounded up so it is never short
   // a stray state falls through to run rather than hanging the array
   always_comb
   begin
      next_puState = puState;
      case (puState)
         PMCA_PU_CLEAR: next_puState = PMCA_PU_WAIT;
         PMCA_PU_WAIT:
            if (puCount == PRC_LAST)
               next_puState = PMCA_PU_RUN;
         default: next_puState = PMCA_PU_RUN;
      endcase
   end

   // sequencer state, back to clear on every reset
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         puState <= PMCA_PU_CLEAR;
      else
         puState <= next_puState;
   end

   // interval counter runs only while waiting and rests at zero elsewhere
   always_ff @(posedge core_clk)
   begin
      if (!rstn || puState != PMCA_PU_WAIT)
         puCount <= '0;
      else
         puCount <= puCount + PRC_W'(1);
   end

   // registers are forced low for the single clear cycle
   assign puClear = (puState == PMCA_PU_CLEAR);

   // clock pin edge detect; edges ignored until interval done, which the driver respects
   // the sample register resets low like the idle pin, so reset makes no false edge
   // limitation: pin edges closer than two core clocks apart are lost
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         clkPinQ <= 1'b0;
      else
         clkPinQ <= clkPin;
   end

   assign clkEdge = clkPin && !clkPinQ && (puState == PMCA_PU_RUN);

   // registered mode wins whenever any cell uses its register
   genvar k;
   generate
      for (k = 0; k < CELLS; k++)
      begin : g_is_reg
         assign cellIsReg[k] = (cellCfg[k] == PMCA_CELL_REG);
      end
   endgenerate

   // the written mode only applies while no cell is registered
   assign anyReg = |cellIsReg;
   assign mode = anyReg ? PMCA_MODE_REGISTERED : modeCfg;

   // array inputs: dedicated pins plus per-cell feedback
   // registered cells feed back their register, not the pin, so state survives a
   // disabled driver; outer cells in complex mode have no pin path and read high
   genvar f;
   generate
      for (f = 0; f < CELLS; f++)
      begin : g_fb
         localparam bit OUTER_CELL = (f == OUTER_LO) || (f == OUTER_HI);
         logic fbReg;
         logic fbCut;

         assign fbReg = (mode == PMCA_MODE_REGISTERED) && (cellCfg[f] == PMCA_CELL_REG);
         assign fbCut = OUTER_CELL && (mode == PMCA_MODE_COMPLEX);

         // one cell's feedback bit
         always_comb
         begin
            if (fbReg)
               fbVal[f] = regQ[f];
            else if (fbCut)
               fbVal[f] = 1'b1;
            else
               fbVal[f] = ioIn[f] | ~ioDriven[f];
         end
      end
   endgenerate

   assign arrayIn = {fbVal, inVal};
   assign lits = {~arrayIn, arrayIn};

   // config port decode
   assign preloadStb = req.wr && (req.addr == OFS_PRELOAD) && !fuse;
   assign preloadMask = req.wdata[PRELOAD_EN_LSB +: CELLS];
   assign preloadVals = req.wdata[PRELOAD_VAL_LSB +: CELLS];
   // term window: sixteen addresses per cell, ten words used, so all eight cells
   // fit below the top of the 8-bit address space; the six spare words are ignored
   // addresses past the window are dropped rather than wrapped onto a cell
   assign termIdx = req.addr - OFS_TERM_BASE;
   assign termCell = termIdx[6:4];
   assign termWord = {1'b0, termIdx[3:0]};
   assign termHit = (req.addr >= OFS_TERM_BASE) && !termIdx[7] && (termWord < 5'd10);

   // written mode: only the complex code selects complex, anything else is simple
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         modeCfg <= PMCA_MODE_SIMPLE;
      else if (req.wr && req.addr == OFS_MODE)
      begin
         if (req.wdata[1:0] == 2'h1)
            modeCfg <= PMCA_MODE_COMPLEX;
         else
            modeCfg <= PMCA_MODE_SIMPLE;
      end
   end

   // cell configuration with fixed-function overrides per mode
   // two bits per cell cover all four kinds, so no code is left undecoded
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         for (int c = 0; c < CELLS; c++)
            cellCfg[c] <= PMCA_CELL_INPUT;
      end
      else if (req.wr && req.addr == OFS_CELLCFG)
      begin
         for (int c = 0; c < CELLS; c++)
            cellCfg[c] <= pmca_cell_t'(req.wdata[2*c +: 2]);
      end
   end

   // term array storage: ten 32-bit words hold a cell's eight 40-bit terms
   // writes stay open after the fuse; only readback is shut
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         for (int c = 0; c < CELLS; c++)
            termMem[c] <= '0;
      end
      else if (req.wr && termHit)
         termMem[termCell][32*termWord +: 32] <= req.wdata;
   end

   // fuse is sticky once written, cleared only by reset
   // it shuts readback and preload from the next cycle on; the signature stays open
   // set it last: a preload after it is silently lost
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         fuse <= 1'b0;
      else if (req.wr && req.addr == OFS_FUSE && req.wdata[0])
         fuse <= 1'b1;
   end

   // user signature stays writable and readable whatever the fuse
   // the halves are written apart, so a half-updated value can be read between
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         signature <= SIG_RESET;
      else if (req.wr && req.addr == OFS_SIG_LO)
         signature[31:0] <= req.wdata;
      else if (req.wr && req.addr == OFS_SIG_HI)
         signature[63:32] <= req.wdata;
   end

   // macrocells
   // each cell sees the whole literal bus; its own masks pick its terms
   genvar g;
   generate
      for (g = 0; g < CELLS; g++)
      begin : g_cell
         pmca_cell #(
            .IS_OUTER(g == OUTER_LO || g == OUTER_HI),
            .IS_CENTRE(g == CENTRE_LO || g == CENTRE_HI)
         ) u_cell (
            .core_clk(core_clk),
            .rstn(rstn),
            .lits(lits),
            .termMask(termMem[g]),
            .mode(mode),
            .cfg(cellCfg[g]),
            .clkEdge(clkEdge),
            .extOeN(oePinN),
            .puClear(puClear),
            .preloadEn(preloadStb && preloadMask[g]),
            .preloadVal(preloadVals[g]),
            .regQ(regQ[g]),
            .pinOut(pinOut[g]),
            .pinOe(pinOe[g])
         );
      end
   endgenerate

   // pins registered, so every output leaves from a flip-flop one cycle late
   // drivers come up off and levels high; in simple mode the centre cells drive from the cycle after reset
   // the one-cycle lag is the price of glitch-free pins
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         ioOut <= {CELLS{1'b1}};
         ioOe <= '0;
      end
      else
      begin
         ioOut <= pinOut;
         ioOe <= pinOe;
      end
   end

   // done flag follows the sequencer one cycle late
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         powerUpDone <= 1'b0;
      else
         powerUpDone <= (puState == PMCA_PU_RUN);
   end

   // read mux; pattern reads return zero once fused
   // unmapped addresses read as zero; the status word shows run and fuse
   always_comb
   begin
      cfgPacked = '0;
      for (int c = 0; c < CELLS; c++)
         cfgPacked[2*c +: 2] = cellCfg[c];
      next_rdata = '0;
      if (req.addr == OFS_MODE)
         next_rdata = {30'h0, mode};
      else if (req.addr == OFS_CELLCFG)
         next_rdata = {16'h0, cfgPacked};
      else if (req.addr == OFS_FUSE)
         next_rdata = {31'h0, fuse};
      else if (req.addr == OFS_STATE)
         next_rdata = {24'h0, regQ};
      else if (req.addr == OFS_SIG_LO)
         next_rdata = signature[31:0];
      else if (req.addr == OFS_SIG_HI)
         next_rdata = signature[63:32];
      else if (req.addr == OFS_STATUS)
         next_rdata = {30'h0, fuse, puState == PMCA_PU_RUN};
      else if (termHit && !fuse)
         next_rdata = termMem[termCell][32*termWord +: 32];
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
         rdata <= '0;
      else if (req.rd)
         rdata <= next_rdata;
      else
         rdata <= '0;
   end
endmodule : pmca_top

// File: verilog/pmca_pkg.sv
// package for the macrocell logic array: modes, cell configurations, sizes, timing
// assumes a single 40 MHz core clock and a synchronous active-low reset
package pmca_pkg;
   localparam int CELLS = 8;
   localparam int ARRAY_INPUTS = 12;
   localparam int TERM_WIDTH = 2 * (ARRAY_INPUTS + CELLS);
   localparam int TERMS_PER_CELL = 8;
   localparam int SIG_BITS = 64;
   localparam int CLK_PERIOD_NS = 25;
   localparam int POWER_UP_RESET_INTERVAL_NS = 1000;
   localparam int POWER_UP_RESET_CYCLES =
      (POWER_UP_RESET_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PRC_W = 6;
   localparam logic [PRC_W-1:0] PRC_LAST = PRC_W'(POWER_UP_RESET_CYCLES - 1);
   localparam logic [CELLS-1:0] REG_RESET = 8'h00;
   localparam logic [SIG_BITS-1:0] SIG_RESET = 64'h0000_0000_0000_0000;
   localparam int OUTER_LO = 0;
   localparam int OUTER_HI = 7;
   localparam int CENTRE_LO = 3;
   localparam int CENTRE_HI = 4;
   localparam int ADDR_W = 8;
   // register port offsets
   localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CELLCFG = 8'h01;
   localparam logic [ADDR_W-1:0] OFS_FUSE = 8'h02;
   localparam logic [ADDR_W-1:0] OFS_PRELOAD = 8'h03;
   localparam logic [ADDR_W-1:0] OFS_STATE = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_SIG_LO = 8'h05;
   localparam logic [ADDR_W-1:0] OFS_SIG_HI = 8'h06;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h07;
   localparam logic [ADDR_W-1:0] OFS_TERM_BASE = 8'h40;
   localparam int PRELOAD_EN_LSB = 8;
   localparam int PRELOAD_VAL_LSB = 0;

   typedef enum logic [1:0]
   {
      PMCA_MODE_SIMPLE = 2'h0,
      PMCA_MODE_COMPLEX = 2'h1,
      PMCA_MODE_REGISTERED = 2'h3
   } pmca_mode_t;

   typedef enum logic [1:0]
   {
      PMCA_CELL_INPUT = 2'h0,
      PMCA_CELL_COMB_OUT = 2'h1,
      PMCA_CELL_COMB_IO = 2'h3,
      PMCA_CELL_REG = 2'h2
   } pmca_cell_t;

   // power-up sequencer: gray path cleared -> counting -> running
   typedef enum logic [1:0]
   {
      PMCA_PU_CLEAR = 2'h0,
      PMCA_PU_WAIT = 2'h1,
      PMCA_PU_RUN = 2'h3
   } pmca_pu_t;

   // register port request
   typedef struct packed
   {
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } pmca_req_t;

   // pin signals of all macrocells, one bit per cell
   typedef struct packed
   {
      logic [CELLS-1:0] out;
      logic [CELLS-1:0] oe;
   } pmca_pins_t;
endpackage : pmca_pkg

// File: verilog/pmca_cell.sv
// one macrocell: eight product terms, sum, register, output and enable select
// assumes term bits arrive from the shared array literals, true/complement pairs
`timescale 1ns/1ps
module pmca_cell
   import pmca_pkg::*;
#(
   parameter bit IS_OUTER = 1'b0,
   parameter bit IS_CENTRE = 1'b0
)
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [TERM_WIDTH-1:0] lits,
   input wire logic [TERMS_PER_CELL*TERM_WIDTH-1:0] termMask,
   input wire pmca_mode_t mode,
   input wire pmca_cell_t cfg,
   input wire logic clkEdge,
   input wire logic extOeN,
   input wire logic puClear,
   input wire logic preloadEn,
   input wire logic preloadVal,
   output logic regQ,
   output logic pinOut,
   output logic pinOe
);
   logic [TERMS_PER_CELL-1:0] terms;
   logic sum8;
   logic sum7;

   // each term ANDs the selected literals; an all-zero mask gives a true term
   genvar t;
   generate
      for (t = 0; t < TERMS_PER_CELL; t++)
      begin : g_term
         assign terms[t] = &(lits | ~termMask[t*TERM_WIDTH +: TERM_WIDTH]);
      end
   endgenerate

   assign sum8 = |terms;
   assign sum7 = |terms[TERMS_PER_CELL-1:1];

   // register cleared at power-up, loaded on clock pin edge, or preloaded
   always_ff @(posedge core_clk)
   begin
      if (!rstn || puClear)
         regQ <= 1'b0;
      else if (preloadEn)
         regQ <= preloadVal;
      else if (clkEdge && mode == PMCA_MODE_REGISTERED && cfg == PMCA_CELL_REG)
         regQ <= sum8;
   end

   // output path per mode and configuration
   always_comb
   begin
      pinOut = 1'b0;
      pinOe = 1'b0;
      case (mode)
         PMCA_MODE_REGISTERED:
         begin
            if (cfg == PMCA_CELL_REG)
            begin
               pinOut = ~regQ;
               pinOe = ~extOeN;
            end
            else if (cfg != PMCA_CELL_INPUT)
            begin
               pinOut = sum7;
               pinOe = terms[0];
            end
            else
               pinOe = 1'b0;
         end
         PMCA_MODE_COMPLEX:
         begin
            pinOut = sum7;
            pinOe = (cfg != PMCA_CELL_INPUT || IS_OUTER) ? terms[0] : 1'b0;
         end
         default:
         begin
            pinOut = sum8;
            pinOe = (cfg != PMCA_CELL_INPUT || IS_CENTRE);
         end
      endcase
   end
endmodule : pmca_cell

// File: bench/pmca_top_sva.sv
// checker for the macrocell array top: power-up, register port, enables
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module pmca_top_sva
   import pmca_pkg::*;
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic oePinN,
   input wire pmca_req_t req,
   input wire logic [31:0] rdata,
   input wire logic [CELLS-1:0] ioOe,
   input wire logic [CELLS-1:0] ioOut,
   input wire logic powerUpDone
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   logic [7:0] puCnt;
   logic [31:0] sigLo;
   logic fuse;
   logic [15:0] cfg;
   logic [CELLS-1:0] regMask;
   logic [CELLS-1:0] inMask;
   // shadows of software writes, and the power-up wait
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         puCnt <= 8'h00;
         sigLo <= 32'h0;
         fuse <= 1'b0;
         cfg <= 16'h0;
      end
      else
      begin
         if (!powerUpDone)
            puCnt <= puCnt + 8'h01;
         if (req.wr && req.addr == OFS_SIG_LO)
            sigLo <= req.wdata;
         if (req.wr && req.addr == OFS_FUSE && req.wdata[0])
            fuse <= 1'b1;
         if (req.wr && req.addr == OFS_CELLCFG)
            cfg <= req.wdata[15:0];
      end
   end
   // per-cell kind masks
   always_comb
   begin
      for (int c = 0; c < CELLS; c++)
      begin
         regMask[c] = cfg[2*c +: 2] == 2'h2;
         inMask[c] = cfg[2*c +: 2] == 2'h0;
      end
   end
   reset_out_a: assert property (rstn && !$past(rstn) |-> ioOut == 8'hff && ioOe == 8'h00)
      else $error("pins not idle after reset");
   pu_early_a: assert property (powerUpDone |-> puCnt >= 8'd40)
      else $error("power-up ended early");
   pu_late_a: assert property (puCnt <= 8'd48)
      else $error("power-up never ended");
   done_hold_a: assert property (powerUpDone |=> powerUpDone)
      else $error("power-up done dropped");
   sig_read_a: assert property ($past(req.rd && req.addr == OFS_SIG_LO) |-> rdata == $past(sigLo))
      else $error("signature read wrong");
   fuse_hide_a: assert property ($past(req.rd && req.addr >= OFS_TERM_BASE && fuse) |-> rdata == 32'h0)
      else $error("pattern readable under fuse");
   status_fuse_a: assert property ($past(req.rd && req.addr == OFS_STATUS) |-> rdata[1] == $past(fuse))
      else $error("fuse status wrong");
   mode_reg_a: assert property ($past(req.rd && req.addr == OFS_MODE && |regMask) |-> rdata[1:0] == 2'h3)
      else $error("registered mode not shown");
   reg_oe_a: assert property (powerUpDone && $stable(cfg) && |regMask |-> ((ioOe ^ {CELLS{!$past(oePinN)}}) & regMask) == 8'h00)
      else $error("register enable not from pin");
   in_off_a: assert property (|regMask && $stable(cfg) |-> (ioOe & inMask) == 8'h00)
      else $error("input cell driving");
   cover property (powerUpDone && !$past(powerUpDone));
   cover property ($past(req.rd && fuse && req.addr >= OFS_TERM_BASE));
   cover property (|regMask && !oePinN);
endmodule : pmca_top_sva

bind pmca_top pmca_top_sva chk_i (.core_clk, .rstn, .oePinN, .req, .rdata, .ioOe, .ioOut,
   .powerUpDone);

// File: bench/pmca_board.sv
// board model: drives array inputs, the clock pin and the enable pin
// assumes callers use drive before tick; undriven lines wander
`timescale 1ns/1ps
module pmca_board
   import pmca_pkg::*;
(
   input wire logic core_clk,
   input wire logic powerUpDone,
   output logic clkPin,
   output logic [ARRAY_INPUTS-1:0] inPins,
   output logic [ARRAY_INPUTS-1:0] inDriven,
   output logic [CELLS-1:0] ioIn,
   output logic [CELLS-1:0] ioDriven,
   output logic oePinN
);
   logic [ARRAY_INPUTS-1:0] inVal = '0;
   initial
   begin
      clkPin = 1'b0;
      inPins = '0;
      inDriven = '0;
      ioIn = '0;
      ioDriven = '0;
      oePinN = 1'b1;
   end
   // released lines toggle so only the pull-up view can match
   always @(posedge core_clk)
   begin
      inPins <= (inVal & inDriven) | (~inPins & ~inDriven);
      ioIn <= ~ioIn & ~ioDriven;
   end
   task automatic drive(input logic [11:0] v, input logic [11:0] d, input logic oe);
      @(posedge core_clk);
      inVal <= v;
      inDriven <= d;
      oePinN <= oe;
      repeat (3) @(posedge core_clk); // setup met well before the clock
      #1;
   endtask : drive
   task automatic tick();
      @(posedge core_clk);
      clkPin <= powerUpDone; // held low through power-up
      @(posedge core_clk);
      clkPin <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask : tick
endmodule : pmca_board

// File: bench/pmca_top_tb.sv
// bench for the macrocell array: power-up, clocking, preload, modes, fuse
// assumes the board model drives the pins and the checker is bound
`timescale 1ns/1ps
module pmca_top_tb
   import pmca_pkg::*;
;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   pmca_req_t req = '0;
   logic [31:0] rdata;
   logic [CELLS-1:0] ioOut, ioOe, ioIn, ioDriven;
   logic [ARRAY_INPUTS-1:0] inPins, inDriven;
   logic powerUpDone, clkPin, oePinN;
   int miscompares = 0;
   int n_compared = 0;
   int n;
   logic [7:0] st;
   logic [1:0] q;
   logic [31:0] r;
   logic [63:0] sig;
   logic [319:0] tv;
   always #12.5 core_clk = ~core_clk;
   pmca_top uut (.core_clk, .rstn, .inPins, .inDriven, .ioIn, .ioDriven, .clkPin, .oePinN,
      .req, .rdata, .ioOut, .ioOe, .powerUpDone);
   pmca_board board (.core_clk, .powerUpDone, .clkPin, .inPins, .inDriven, .ioIn, .ioDriven,
      .oePinN);
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge core_clk);
      req.wr <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
      @(posedge core_clk);
      req <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge core_clk);
      req.rd <= 1'b0;
      #1 chk(rdata & m, e);
   endtask : rd
   // term 0 holds one literal; terms 1..7 need input 0 and its inverse, never true
   function automatic logic [319:0] terms(input int lit);
      logic [319:0] v;
      v = '0;
      for (int t = 1; t < 8; t++)
         v[t*40 +: 21] = 21'h100001;
      v[lit] = 1'b1;
      return v;
   endfunction : terms
   task automatic set_cell(input int c, input int lit);
      logic [319:0] v;
      v = terms(lit);
      for (int w = 0; w < 10; w++)
         wr(8'(OFS_TERM_BASE + c*16 + w), v[w*32 +: 32]);
   endtask : set_cell
   initial
   begin
      void'($urandom(99));
      repeat (10) @(posedge core_clk);
      rstn <= 1'b1;
      #1 chk({ioOut, ioOe, powerUpDone}, {8'hff, 8'h00, 1'b0});
      n = 0;
      while (powerUpDone !== 1'b1 && n < 60)
      begin
         @(posedge core_clk);
         #1 n++;
      end
      chk(n >= 40 && n < 50, 1);
      rd(OFS_STATE, 0);
      rd(8'h20, 0);
      wr(OFS_CELLCFG, 32'h000a);
      set_cell(0, 32);
      set_cell(1, 1);
      rd(OFS_MODE, 3);
      board.drive(12'h0, 12'h0, 1'b0);
      chk({ioOe, ioOut[1:0]}, {8'h03, 2'b11});
      // cell 0 toggles through feedback, cell 1 follows input 1
      q = 2'b00;
      repeat (8)
      begin
         r = $urandom;
         board.drive(r[11:0], r[23:12], r[24]);
         board.tick();
         q = {r[1] | ~r[13], ~q[0]};
         rd(OFS_STATE, q, 3);
         chk({ioOe, ioOut[1:0]}, {6'h0, {2{~r[24]}}, ~q});
      end
      st = $urandom;
      wr(OFS_PRELOAD, {16'h0, 8'hff, st});
      repeat (6)
      begin
         r = $urandom;
         st = (st & ~r[15:8]) | (r[7:0] & r[15:8]);
         wr(OFS_PRELOAD, {16'h0, r[15:0]});
         rd(OFS_STATE, st);
      end
      chk(ioOut[1:0], {~st[1:0]});
      wr(OFS_CELLCFG, 0);
      wr(OFS_MODE, 0);
      rd(OFS_MODE, 0);
      chk(ioOe, 8'h18);
      wr(OFS_CELLCFG, 32'h0004);
      wr(OFS_MODE, 1);
      rd(OFS_MODE, 1);
      repeat (4)
      begin
         r = $urandom;
         board.drive(r[11:0], r[23:12], 1'b1);
         chk(ioOe[1], {r[1] | ~r[13]});
      end
      sig = {$urandom, $urandom};
      wr(OFS_SIG_LO, sig[31:0]);
      wr(OFS_SIG_HI, sig[63:32]);
      tv = terms(32);
      rd(8'h41, tv[63:32]);
      wr(OFS_FUSE, 1); // configuration done first
      rd(8'h41, 0);
      wr(OFS_PRELOAD, {16'h0, 8'hff, ~st});
      rd(OFS_STATE, st);
      rd(OFS_STATUS, 2, 2);
      rd(OFS_SIG_LO, sig[31:0]);
      rd(OFS_SIG_HI, sig[63:32]);
      give_verdict();
   end
   // hang guard, far beyond the expected run
   initial
   begin
      #(25 * 4000);
      miscompares++;
      give_verdict();
   end
endmodule : pmca_top_tb
